// [inc/phy_autoneg_map.vh]
/*
 Register map of the auto-negotiation and mode-control register slice:
 register indices, field positions, reset values and timing figures.
 Assumes it is included by its bare name from the design files.
*/
`ifndef PHY_AUTONEG_MAP_VH
`define PHY_AUTONEG_MAP_VH

// Register indices on the 5-bit management register address.
`define REG_ADV_IDX 5'h04
`define REG_PARTNER_IDX 5'h05
`define REG_EXPANSION_IDX 5'h06
`define REG_REVISION_IDX 5'h10
`define REG_MODE_CTRL_IDX 5'h11

// Advertisement register fields.
`define ADV_T4_BIT 9
`define ADV_100FD_BIT 8
`define ADV_100HD_BIT 7
`define ADV_10FD_BIT 6
`define ADV_10HD_BIT 5
`define ADV_SEL_MSB 4
`define ADV_SEL_LSB 0
`define ADV_T4_RESET 1'h0
`define ADV_100HD_RESET 1'h1
`define SELECTOR_8023 5'h01

// Link partner ability register fields.
`define LPA_NEXT_PAGE_BIT 15
`define LPA_ACK_BIT 14
`define LPA_REMOTE_FAULT_BIT 13
`define LPA_PAUSE_BIT 10
`define LPA_T4_BIT 9
`define LPA_100FD_BIT 8
`define LPA_100HD_BIT 7
`define LPA_10FD_BIT 6
`define LPA_10HD_BIT 5
`define LPA_SEL_MSB 4
`define LPA_SEL_LSB 0
`define LPA_NEXT_PAGE_RESET 1'h0
`define LPA_T4_RESET 1'h0

// Expansion register fields.
`define EXP_PD_FAULT_BIT 4
`define EXP_LP_NEXT_PAGE_BIT 3
`define EXP_NEXT_PAGE_ABLE_BIT 2
`define EXP_PAGE_RX_BIT 1
`define EXP_LP_AN_ABLE_BIT 0
`define EXP_NEXT_PAGE_ABLE_RESET 1'h0

// Silicon revision register field.
`define REV_MSB 9
`define REV_LSB 6

// Mode control register fields.
`define MODE_RSVD_HI_MSB 15
`define MODE_RSVD_HI_LSB 14
`define MODE_EDPD_BIT 13
`define MODE_RSVD_MID_BIT 12
`define MODE_LOW_SQ_BIT 11
`define MODE_PRE_BP_BIT 10
`define MODE_FAR_LOOP_BIT 9
`define MODE_RSVD_LO_MSB 8
`define MODE_RSVD_LO_LSB 7
`define MODE_ENERGY_BIT 1
`define MODE_CTRL_RESET 16'h0000

// Energy-present timeout and clock rate.
`define ENERGY_TIMEOUT_MS 256
`define CLK_FREQ_HZ 25000000
`define ENERGY_PRESENT_RESET 1'h1

`endif

// [hdl/energy_timer.v]
/*
 Line energy watchdog: holds the energy-present indication high while valid
 line energy keeps arriving and drops it after a quiet interval.
 Assumes energy_seen_i is synchronous to clk_i and the interval is given in
 clock cycles by the instantiating module.
*/
`timescale 1ns/1ps
`include "phy_autoneg_map.vh"

module energy_timer #(
   parameter integer TIMEOUT_CYCLES = 6400000,
   parameter integer CNT_W = 23
)(
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   input wire energy_seen_i,
   output reg present_o
);

   localparam [CNT_W-1:0] LAST = TIMEOUT_CYCLES[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};

   reg [CNT_W-1:0] quiet_q;

   // Hardware reset forces the indication high, so software sees energy until proven otherwise.
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         quiet_q <= {CNT_W{1'b0}};
         present_o <= `ENERGY_PRESENT_RESET;
      end
      else if (ce_i)
      begin
         if (energy_seen_i)
         begin
            quiet_q <= {CNT_W{1'b0}};
            present_o <= 1'b1;
         end
         else if (quiet_q == LAST)
         begin
            present_o <= 1'b0;
         end
         else
         begin
            quiet_q <= quiet_q + {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

endmodule // energy_timer

// [hdl/phy_autoneg_mode_regs.v]
/*
 Management register slice of a 10/100 transceiver: advertisement (low half),
 link partner ability, expansion, silicon revision and the upper mode-control
 bits with their control outputs.
 Assumes a serial management front end that decodes frames and presents one
 register access at a time as a one-cycle strobe with a 5-bit register index,
 and auto-negotiation logic that reports received pages as one-cycle pulses.
*/
`timescale 1ns/1ps
`include "phy_autoneg_map.vh"

// Behaviour
// - Advertised T4 ability bit is read-only zero.
// - Advertised 100FD, 100HD, 10FD, 10HD writable; 100HD resets one, others from straps.
// - Selector fields: writable in advertisement, read-only in partner, both reset 802.3.
// - Partner next-page bit reads zero, read-only.
// - Acknowledge bit sets once a partner link code word arrives; zero after reset.
// - Partner remote-fault bit follows partner signalling; resets zero.
// - Partner pause and speed/duplex abilities captured read-only; reset zero.
// - Partner T4 bit reads zero, read-only.
// - Parallel-detection fault latches high; read-only; resets zero.
// - Expansion bit shows partner next-page ability; resets zero.
// - Own next-page ability reads zero, read-only.
// - Page-received flag latches high on a new page; resets zero.
// - Expansion bit shows partner auto-negotiation ability; upper expansion bits read zero.
// - Revision register shows a four-bit code at 9:6, other bits zero.
// - Energy-detect power-down enable bit, writable, resets zero.
// - Low squelch control equals low-squelch enable AND power-down enable.
// - Low squelch one selects the lower, more sensitive threshold.
// - Preamble-bypass bit lets management frames without preamble be recognised.
// - Far loopback returns received packets simultaneously, in 100TX only.
// - Far loopback works only in reduced-pin mode; partner supplies 50 MHz clock.
// - Far loopback keeps working while the interface is isolated.
// - Energy-present clears after 256 ms without line energy; reset sets it.
module phy_autoneg_mode_regs #(
   parameter [3:0] SILICON_REV = 4'h5,
   parameter integer ENERGY_TIMEOUT_CYCLES = `ENERGY_TIMEOUT_MS * (`CLK_FREQ_HZ / 1000),
   parameter integer ENERGY_CNT_W = 23
)(
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   input wire [2:0] mode_strap_i,
   input wire [4:0] reg_addr_i,
   input wire reg_wr_i,
   input wire [15:0] reg_wdata_i,
   input wire reg_rd_i,
   output reg [15:0] reg_rdata_o,
   output reg reg_rvalid_o,
   input wire page_rx_i,
   input wire [15:0] page_word_i,
   input wire partner_an_able_i,
   input wire pd_fault_i,
   input wire energy_seen_i,
   input wire rmii_mode_i,
   input wire speed_100_i,
   output reg energy_detect_powerdown_en_o,
   output reg sensitive_squelch_o,
   output reg mgmt_preamble_bypass_o,
   output reg far_end_loop_o,
   output reg line_energy_present_o
);

   localparam integer NUM_LH = 2;
   localparam integer LH_PD_FAULT = 0;
   localparam integer LH_PAGE_RX = 1;

   // Strap capture sequence, one-hot.
   localparam [1:0] ST_STRAP = 2'b01;
   localparam [1:0] ST_RUN = 2'b10;

   reg [1:0] state_q;
   reg [1:0] state_d;

   // Advertisement storage.
   reg adv_100fd_q;
   reg adv_100hd_q;
   reg adv_10fd_q;
   reg adv_10hd_q;
   reg [4:0] adv_sel_q;

   // Partner ability storage.
   reg lpa_ack_q;
   reg lpa_rfault_q;
   reg lpa_pause_q;
   reg lpa_100fd_q;
   reg lpa_100hd_q;
   reg lpa_10fd_q;
   reg lpa_10hd_q;
   reg [4:0] lpa_sel_q;
   reg lp_next_page_q;
   reg lp_an_able_q;

   // Mode-control storage, reserved bits included since they are read/write cells.
   reg [1:0] mode_rsvd_hi_q;
   reg mode_rsvd_mid_q;
   reg [1:0] mode_rsvd_lo_q;
   reg edpd_en_q;
   reg low_sq_en_q;
   reg pre_bp_q;
   reg far_loop_q;

   wire energy_present;
   wire wr_adv;
   wire wr_mode;
   wire rd_exp;
   wire [NUM_LH-1:0] lh_event;
   reg [NUM_LH-1:0] lh_q;
   reg [15:0] rdata_d;

   assign wr_adv = ce_i & reg_wr_i & (reg_addr_i == `REG_ADV_IDX) & (state_q == ST_RUN);
   assign wr_mode = ce_i & reg_wr_i & (reg_addr_i == `REG_MODE_CTRL_IDX);
   assign rd_exp = ce_i & reg_rd_i & (reg_addr_i == `REG_EXPANSION_IDX);
   assign lh_event[LH_PD_FAULT] = pd_fault_i;
   assign lh_event[LH_PAGE_RX] = page_rx_i;

   // The straps are level inputs; they are caught by a clocked step after reset release,
   // never loaded by the asynchronous reset itself.
   always @*
   begin
      state_d = state_q;
      case (state_q)
         ST_STRAP: state_d = ST_RUN;
         ST_RUN: state_d = ST_RUN;
         default: state_d = ST_STRAP;
      endcase
   end

   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_q <= ST_STRAP;
      end
      else if (ce_i)
      begin
         state_q <= state_d;
      end
   end

   // Advertisement register.
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         adv_100fd_q <= 1'b0;
         adv_100hd_q <= `ADV_100HD_RESET;
         adv_10fd_q <= 1'b0;
         adv_10hd_q <= 1'b0;
         adv_sel_q <= `SELECTOR_8023;
      end
      else if (ce_i)
      begin
         if (state_q == ST_STRAP)
         begin
            adv_100fd_q <= mode_strap_i[2];
            adv_10fd_q <= mode_strap_i[1];
            adv_10hd_q <= mode_strap_i[0];
         end
         else if (wr_adv)
         begin
            adv_100fd_q <= reg_wdata_i[`ADV_100FD_BIT];
            adv_100hd_q <= reg_wdata_i[`ADV_100HD_BIT];
            adv_10fd_q <= reg_wdata_i[`ADV_10FD_BIT];
            adv_10hd_q <= reg_wdata_i[`ADV_10HD_BIT];
            adv_sel_q <= reg_wdata_i[`ADV_SEL_MSB:`ADV_SEL_LSB];
         end
      end
   end

   // Partner ability is refreshed from every received base page.
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         lpa_ack_q <= 1'b0;
         lpa_rfault_q <= 1'b0;
         lpa_pause_q <= 1'b0;
         lpa_100fd_q <= 1'b0;
         lpa_100hd_q <= 1'b0;
         lpa_10fd_q <= 1'b0;
         lpa_10hd_q <= 1'b0;
         lpa_sel_q <= `SELECTOR_8023;
         lp_next_page_q <= 1'b0;
         lp_an_able_q <= 1'b0;
      end
      else if (ce_i)
      begin
         lp_an_able_q <= partner_an_able_i;
         if (page_rx_i)
         begin
            lpa_ack_q <= 1'b1;
            lpa_rfault_q <= page_word_i[`LPA_REMOTE_FAULT_BIT];
            lpa_pause_q <= page_word_i[`LPA_PAUSE_BIT];
            lpa_100fd_q <= page_word_i[`LPA_100FD_BIT];
            lpa_100hd_q <= page_word_i[`LPA_100HD_BIT];
            lpa_10fd_q <= page_word_i[`LPA_10FD_BIT];
            lpa_10hd_q <= page_word_i[`LPA_10HD_BIT];
            lpa_sel_q <= page_word_i[`LPA_SEL_MSB:`LPA_SEL_LSB];
            lp_next_page_q <= page_word_i[`LPA_NEXT_PAGE_BIT];
         end
      end
   end

   // Latched-high flags: an event in the same cycle as the clearing read wins,
   // so a fault arriving during the read is never lost.
   genvar gi;
   generate
      for (gi = 0; gi < NUM_LH; gi = gi + 1)
      begin : g_lh
         always @(posedge clk_i or posedge rst_i)
         begin
            if (rst_i)
            begin
               lh_q[gi] <= 1'b0;
            end
            else if (ce_i)
            begin
               if (lh_event[gi])
               begin
                  lh_q[gi] <= 1'b1;
               end
               else if (rd_exp)
               begin
                  lh_q[gi] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   localparam [15:0] MODE_RST = `MODE_CTRL_RESET;
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         mode_rsvd_hi_q <= MODE_RST[`MODE_RSVD_HI_MSB:`MODE_RSVD_HI_LSB];
         edpd_en_q <= MODE_RST[`MODE_EDPD_BIT];
         mode_rsvd_mid_q <= MODE_RST[`MODE_RSVD_MID_BIT];
         low_sq_en_q <= MODE_RST[`MODE_LOW_SQ_BIT];
         pre_bp_q <= MODE_RST[`MODE_PRE_BP_BIT];
         far_loop_q <= MODE_RST[`MODE_FAR_LOOP_BIT];
         mode_rsvd_lo_q <= MODE_RST[`MODE_RSVD_LO_MSB:`MODE_RSVD_LO_LSB];
      end
      else if (wr_mode)
      begin
         // Reserved cells keep whatever is written; software is expected to write zero.
         mode_rsvd_hi_q <= reg_wdata_i[`MODE_RSVD_HI_MSB:`MODE_RSVD_HI_LSB];
         edpd_en_q <= reg_wdata_i[`MODE_EDPD_BIT];
         mode_rsvd_mid_q <= reg_wdata_i[`MODE_RSVD_MID_BIT];
         low_sq_en_q <= reg_wdata_i[`MODE_LOW_SQ_BIT];
         pre_bp_q <= reg_wdata_i[`MODE_PRE_BP_BIT];
         far_loop_q <= reg_wdata_i[`MODE_FAR_LOOP_BIT];
         mode_rsvd_lo_q <= reg_wdata_i[`MODE_RSVD_LO_MSB:`MODE_RSVD_LO_LSB];
      end
   end

   // Control outputs, registered so that each follows its enable one cycle later.
   // Far loopback deliberately ignores interface isolate, so a test rig can loop the
   // line while the MAC side is disconnected.
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         energy_detect_powerdown_en_o <= 1'b0;
         sensitive_squelch_o <= 1'b0;
         mgmt_preamble_bypass_o <= 1'b0;
         far_end_loop_o <= 1'b0;
      end
      else if (ce_i)
      begin
         energy_detect_powerdown_en_o <= edpd_en_q;
         sensitive_squelch_o <= low_sq_en_q & edpd_en_q;
         mgmt_preamble_bypass_o <= pre_bp_q;
         far_end_loop_o <= far_loop_q & rmii_mode_i & speed_100_i;
      end
   end

   energy_timer #(
      .TIMEOUT_CYCLES(ENERGY_TIMEOUT_CYCLES),
      .CNT_W(ENERGY_CNT_W)
   ) u_energy_timer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .energy_seen_i(energy_seen_i),
      .present_o(energy_present)
   );

   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         line_energy_present_o <= `ENERGY_PRESENT_RESET;
      end
      else if (ce_i)
      begin
         line_energy_present_o <= energy_present;
      end
   end

   // Read multiplexer; unmapped indices and reserved bits read zero, except mode-control reserved cells, which read back as written.
   always @*
   begin
      rdata_d = 16'h0000;
      case (reg_addr_i)
         `REG_ADV_IDX:
         begin
            rdata_d[`ADV_T4_BIT] = `ADV_T4_RESET;
            rdata_d[`ADV_100FD_BIT] = adv_100fd_q;
            rdata_d[`ADV_100HD_BIT] = adv_100hd_q;
            rdata_d[`ADV_10FD_BIT] = adv_10fd_q;
            rdata_d[`ADV_10HD_BIT] = adv_10hd_q;
            rdata_d[`ADV_SEL_MSB:`ADV_SEL_LSB] = adv_sel_q;
         end
         `REG_PARTNER_IDX:
         begin
            rdata_d[`LPA_NEXT_PAGE_BIT] = `LPA_NEXT_PAGE_RESET;
            rdata_d[`LPA_ACK_BIT] = lpa_ack_q;
            rdata_d[`LPA_REMOTE_FAULT_BIT] = lpa_rfault_q;
            rdata_d[`LPA_PAUSE_BIT] = lpa_pause_q;
            rdata_d[`LPA_T4_BIT] = `LPA_T4_RESET;
            rdata_d[`LPA_100FD_BIT] = lpa_100fd_q;
            rdata_d[`LPA_100HD_BIT] = lpa_100hd_q;
            rdata_d[`LPA_10FD_BIT] = lpa_10fd_q;
            rdata_d[`LPA_10HD_BIT] = lpa_10hd_q;
            rdata_d[`LPA_SEL_MSB:`LPA_SEL_LSB] = lpa_sel_q;
         end
         `REG_EXPANSION_IDX:
         begin
            rdata_d[`EXP_PD_FAULT_BIT] = lh_q[LH_PD_FAULT];
            rdata_d[`EXP_LP_NEXT_PAGE_BIT] = lp_next_page_q;
            rdata_d[`EXP_NEXT_PAGE_ABLE_BIT] = `EXP_NEXT_PAGE_ABLE_RESET;
            rdata_d[`EXP_PAGE_RX_BIT] = lh_q[LH_PAGE_RX];
            rdata_d[`EXP_LP_AN_ABLE_BIT] = lp_an_able_q;
         end
         `REG_REVISION_IDX:
         begin
            rdata_d[`REV_MSB:`REV_LSB] = SILICON_REV;
         end
         `REG_MODE_CTRL_IDX:
         begin
            rdata_d[`MODE_RSVD_HI_MSB:`MODE_RSVD_HI_LSB] = mode_rsvd_hi_q;
            rdata_d[`MODE_EDPD_BIT] = edpd_en_q;
            rdata_d[`MODE_RSVD_MID_BIT] = mode_rsvd_mid_q;
            rdata_d[`MODE_LOW_SQ_BIT] = low_sq_en_q;
            rdata_d[`MODE_PRE_BP_BIT] = pre_bp_q;
            rdata_d[`MODE_FAR_LOOP_BIT] = far_loop_q;
            rdata_d[`MODE_RSVD_LO_MSB:`MODE_RSVD_LO_LSB] = mode_rsvd_lo_q;
            rdata_d[`MODE_ENERGY_BIT] = line_energy_present_o;
         end
         default:
         begin
            rdata_d = 16'h0000;
         end
      endcase
   end

   // Read data is held until the next read so the serial front end may shift it out slowly.
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         reg_rdata_o <= 16'h0000;
         reg_rvalid_o <= 1'b0;
      end
      else if (ce_i)
      begin
         reg_rvalid_o <= reg_rd_i;
         if (reg_rd_i)
         begin
            reg_rdata_o <= rdata_d;
         end
      end
   end

endmodule // phy_autoneg_mode_regs

// [verification/phy_autoneg_chk.sv]
/*
 Concurrent checks on the ports of the autoneg and mode-control register slice.
 Assumes it is bound to the top module and that reads answer one cycle later.
*/
`timescale 1ns/1ps
module phy_autoneg_chk #(
   parameter [3:0] SILICON_REV = 4'h5
)(
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   input wire [4:0] reg_addr_i,
   input wire reg_wr_i,
   input wire [15:0] reg_wdata_i,
   input wire reg_rd_i,
   input wire [15:0] reg_rdata_o,
   input wire reg_rvalid_o,
   input wire page_rx_i,
   input wire pd_fault_i,
   input wire energy_seen_i,
   input wire rmii_mode_i,
   input wire speed_100_i,
   input wire energy_detect_powerdown_en_o,
   input wire sensitive_squelch_o,
   input wire mgmt_preamble_bypass_o,
   input wire far_end_loop_o,
   input wire line_energy_present_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_rd(a);
      ce_i && reg_rd_i && reg_addr_i == a;
   endsequence
   sequence s_page;
      ce_i && page_rx_i;
   endsequence
   sequence s_fault;
      ce_i && pd_fault_i;
   endsequence
   sequence s_wr_mode;
      ce_i && reg_wr_i && reg_addr_i == 5'h11 ##1 ce_i;
   endsequence
   a_adv_t4_zero: assert property (reg_rvalid_o && $past(reg_addr_i) == 5'h04 |-> !reg_rdata_o[9])
      else $error("advertised T4 bit reads one");
   a_partner_fixed_zero: assert property (reg_rvalid_o && $past(reg_addr_i) == 5'h05 |-> !reg_rdata_o[15] && !reg_rdata_o[9])
      else $error("partner next-page or T4 bit reads one");
   a_exp_upper_zero: assert property (reg_rvalid_o && $past(reg_addr_i) == 5'h06 |-> reg_rdata_o[15:5] == 11'h000 && !reg_rdata_o[2])
      else $error("expansion fixed bits read nonzero");
   a_rev_field: assert property (reg_rvalid_o && $past(reg_addr_i) == 5'h10 |-> reg_rdata_o == {6'h00, SILICON_REV, 6'h00})
      else $error("revision register value wrong");
   a_ack_after_page: assert property (s_page ##2 s_rd(5'h05) |=> reg_rvalid_o && reg_rdata_o[14])
      else $error("acknowledge bit not set after a page");
   a_page_flag_set: assert property (s_page ##2 s_rd(5'h06) |=> reg_rvalid_o && reg_rdata_o[1])
      else $error("page received flag not latched");
   a_pd_fault_held: assert property (s_fault ##2 s_rd(5'h06) |=> reg_rvalid_o && reg_rdata_o[4])
      else $error("parallel detection fault not latched");
   a_squelch_and: assert property (sensitive_squelch_o |-> energy_detect_powerdown_en_o)
      else $error("low squelch active without power-down enable");
   a_edpd_follow: assert property (s_wr_mode |=> energy_detect_powerdown_en_o == $past(reg_wdata_i[13], 2))
      else $error("power-down enable does not follow the written bit");
   a_bypass_follow: assert property (s_wr_mode |=> mgmt_preamble_bypass_o == $past(reg_wdata_i[10], 2))
      else $error("preamble bypass does not follow the written bit");
   a_loop_gated: assert property ($past(ce_i) && far_end_loop_o |-> $past(rmii_mode_i) && $past(speed_100_i))
      else $error("far loopback active outside reduced-pin 100TX");
   a_energy_back: assert property (ce_i && energy_seen_i ##1 ce_i |=> line_energy_present_o)
      else $error("energy present not restored");
endmodule // phy_autoneg_chk

bind phy_autoneg_mode_regs phy_autoneg_chk #(.SILICON_REV(SILICON_REV)) chk_u (
   .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
   .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
   .page_rx_i(page_rx_i), .pd_fault_i(pd_fault_i), .energy_seen_i(energy_seen_i), .rmii_mode_i(rmii_mode_i),
   .speed_100_i(speed_100_i), .energy_detect_powerdown_en_o(energy_detect_powerdown_en_o),
   .sensitive_squelch_o(sensitive_squelch_o), .mgmt_preamble_bypass_o(mgmt_preamble_bypass_o),
   .far_end_loop_o(far_end_loop_o), .line_energy_present_o(line_energy_present_o));

// [verification/mgmt_station.sv]
/*
 Model of the station management controller issuing register accesses.
 Assumes the register port takes one-cycle strobes and answers reads a cycle later.
*/
`timescale 1ns/1ps
module mgmt_station (
   input wire clk_i,
   output logic [4:0] reg_addr_o,
   output logic reg_wr_o,
   output logic [15:0] reg_wdata_o,
   output logic reg_rd_o,
   input wire [15:0] reg_rdata_i,
   input wire reg_rvalid_i
);
   initial
   begin
      reg_addr_o = 5'h00;
      reg_wr_o = 1'b0;
      reg_wdata_o = 16'h0000;
      reg_rd_o = 1'b0;
   end
   task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
      @(negedge clk_i);
      reg_addr_o = a;
      reg_wdata_o = (a == 5'h11) ? (d & 16'h2e7f) : d;
      reg_wr_o = 1'b1;
      @(negedge clk_i);
      reg_wr_o = 1'b0;
      // Stale data is inverted so that nothing may lean on it after the strobe.
      reg_wdata_o = ~reg_wdata_o;
   endtask
   task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
      @(negedge clk_i);
      reg_addr_o = a;
      reg_rd_o = 1'b1;
      @(negedge clk_i);
      reg_rd_o = 1'b0;
      d = reg_rvalid_i ? reg_rdata_i : 16'hxxxx;
   endtask
endmodule // mgmt_station

// [verification/testbench.sv]
/*
 Self-checking bench for the autoneg and mode-control register slice.
 Assumes the management model issues all register accesses; the energy timeout is shortened.
*/
`timescale 1ns/1ps
module testbench;
   localparam [3:0] REV = 4'ha; // Arbitrary revision code.
   logic clk_i, rst_i, ce_i, page_rx_i, partner_an_able_i, pd_fault_i;
   logic energy_seen_i, rmii_mode_i, speed_100_i;
   logic [2:0] mode_strap_i;
   logic [15:0] page_word_i;
   wire [4:0] reg_addr_i;
   wire [15:0] reg_wdata_i, reg_rdata_o;
   wire reg_wr_i, reg_rd_i, reg_rvalid_o;
   wire energy_detect_powerdown_en_o, sensitive_squelch_o, mgmt_preamble_bypass_o;
   wire far_end_loop_o, line_energy_present_o;
   int checks = 0;
   int n_mismatch = 0;
   phy_autoneg_mode_regs #(.SILICON_REV(REV), .ENERGY_TIMEOUT_CYCLES(20), .ENERGY_CNT_W(6)) dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .mode_strap_i(mode_strap_i), .reg_addr_i(reg_addr_i),
      .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .reg_rvalid_o(reg_rvalid_o), .page_rx_i(page_rx_i), .page_word_i(page_word_i),
      .partner_an_able_i(partner_an_able_i), .pd_fault_i(pd_fault_i), .energy_seen_i(energy_seen_i),
      .rmii_mode_i(rmii_mode_i), .speed_100_i(speed_100_i),
      .energy_detect_powerdown_en_o(energy_detect_powerdown_en_o), .sensitive_squelch_o(sensitive_squelch_o),
      .mgmt_preamble_bypass_o(mgmt_preamble_bypass_o), .far_end_loop_o(far_end_loop_o),
      .line_energy_present_o(line_energy_present_o));
   mgmt_station mgmt_u (.clk_i(clk_i), .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i),
      .reg_rd_o(reg_rd_i), .reg_rdata_i(reg_rdata_o), .reg_rvalid_i(reg_rvalid_o));
   always #20 clk_i = ~clk_i;
   task automatic give_verdict;
      $display("checks=%0d mismatches=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         n_mismatch++;
      end
   endtask
   task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
      logic [15:0] d;
      mgmt_u.rd_reg(a, d);
      chk(d, exp);
   endtask
   task automatic page(input logic [15:0] w);
      @(negedge clk_i);
      page_rx_i = 1'b1;
      page_word_i = w;
      @(negedge clk_i);
      page_rx_i = 1'b0;
      page_word_i = ~w;
   endtask
   task automatic mode_chk(input logic [15:0] d, input logic [3:0] exp);
      mgmt_u.wr_reg(5'h11, d);
      @(negedge clk_i);
      chk({12'h000, energy_detect_powerdown_en_o, sensitive_squelch_o, mgmt_preamble_bypass_o, far_end_loop_o},
         {12'h000, exp});
   endtask
   initial
   begin
      repeat (5000) @(posedge clk_i);
      n_mismatch++;
      give_verdict();
   end
   initial
   begin
      clk_i = 1'b0;
      rst_i = 1'b1;
      ce_i = 1'b1;
      mode_strap_i = 3'h5;
      page_rx_i = 1'b0;
      page_word_i = 16'h0000;
      partner_an_able_i = 1'b0;
      pd_fault_i = 1'b0;
      energy_seen_i = 1'b1;
      rmii_mode_i = 1'b1;
      speed_100_i = 1'b1;
      repeat (5) @(negedge clk_i);
      rst_i = 1'b0;
      repeat (2) @(negedge clk_i);
      rd_chk(5'h11, 16'h0002);
      rd_chk(5'h04, 16'h01a1);
      rd_chk(5'h05, 16'h0001);
      rd_chk(5'h06, 16'h0000);
      rd_chk(5'h10, {6'h00, REV, 6'h00});
      rd_chk(5'h07, 16'h0000);
      $display("test reset_values done");
      mgmt_u.wr_reg(5'h04, 16'hffff);
      rd_chk(5'h04, 16'h01ff);
      mgmt_u.wr_reg(5'h04, 16'h0000);
      rd_chk(5'h04, 16'h0000);
      mgmt_u.wr_reg(5'h05, 16'h1234);
      rd_chk(5'h05, 16'h0001);
      mgmt_u.wr_reg(5'h06, 16'hffff);
      rd_chk(5'h06, 16'h0000);
      mgmt_u.wr_reg(5'h10, 16'hffff);
      rd_chk(5'h10, {6'h00, REV, 6'h00});
      $display("test access_kinds done");
      partner_an_able_i = 1'b1;
      page(16'hffff);
      rd_chk(5'h05, 16'h65ff);
      rd_chk(5'h06, 16'h000b);
      rd_chk(5'h06, 16'h0009);
      page(16'h0001);
      rd_chk(5'h06, 16'h0003);
      rd_chk(5'h05, 16'h4001);
      @(negedge clk_i);
      pd_fault_i = 1'b1;
      @(negedge clk_i);
      pd_fault_i = 1'b0;
      rd_chk(5'h06, 16'h0011);
      rd_chk(5'h06, 16'h0001);
      partner_an_able_i = 1'b0;
      rd_chk(5'h06, 16'h0000);
      $display("test partner_pages done");
      mode_chk(16'h2800, 4'hc);
      mode_chk(16'h0800, 4'h0);
      mode_chk(16'h2000, 4'h8);
      mode_chk(16'h0400, 4'h2);
      mode_chk(16'h0200, 4'h1);
      rmii_mode_i = 1'b0;
      repeat (2) @(negedge clk_i);
      chk({15'h0000, far_end_loop_o}, 16'h0000);
      rmii_mode_i = 1'b1;
      speed_100_i = 1'b0;
      repeat (2) @(negedge clk_i);
      chk({15'h0000, far_end_loop_o}, 16'h0000);
      speed_100_i = 1'b1;
      mgmt_u.wr_reg(5'h11, 16'hffff);
      rd_chk(5'h11, 16'h2e02);
      ce_i = 1'b0;
      mgmt_u.wr_reg(5'h11, 16'h0000);
      ce_i = 1'b1;
      rd_chk(5'h11, 16'h2e02);
      $display("test mode_control done");
      energy_seen_i = 1'b0;
      repeat (20) @(negedge clk_i);
      chk({15'h0000, line_energy_present_o}, 16'h0001);
      @(negedge clk_i);
      chk({15'h0000, line_energy_present_o}, 16'h0000);
      rd_chk(5'h11, 16'h2e00);
      energy_seen_i = 1'b1;
      repeat (2) @(negedge clk_i);
      chk({15'h0000, line_energy_present_o}, 16'h0001);
      $display("test energy_timeout done");
      give_verdict();
   end
endmodule // testbench
